/* rtl/swbm_pkg.sv */
// Constants and types of the sleep, wake-up and battery monitor block
package swbm_pkg;
  localparam logic [6:0] OFF_SCALE = 7'h14;
  localparam logic [6:0] OFF_MANT_HI = 7'h15;
  localparam logic [6:0] OFF_MANT_LO = 7'h16;
  localparam logic [6:0] OFF_CNT_HI = 7'h17;
  localparam logic [6:0] OFF_CNT_LO = 7'h18;
  localparam logic [6:0] OFF_BAT_THR = 7'h1A;
  localparam logic [6:0] OFF_BAT_LVL = 7'h1B;
  localparam logic [7:0] RST_SCALE = 8'h00;
  localparam logic [7:0] RST_MANT = 8'h00;
  localparam logic [7:0] RST_BAT_THR = 8'h14;
  localparam int CLK_HZ = 40000000;
  localparam int RC_HZ = 32768;
  localparam int BAT_PERIOD_S = 1;
  localparam int BAT_ON_US = 250;
  localparam int RC_DIV_CYC = CLK_HZ / RC_HZ;
  localparam int BAT_PERIOD_CYC = CLK_HZ * BAT_PERIOD_S;
  localparam int BAT_ON_CYC = (CLK_HZ / 1000000) * BAT_ON_US;
  localparam logic [2:0] BAT_HITS = 3'h4;
  localparam logic [4:0] PRESCALE_BASE = 5'h1F;
  localparam int LISTEN_TICKS = 64;
  typedef struct packed {
    logic [3:0]  expo;
    logic [1:0]  fine;
    logic [15:0] mant;
  } swbm_period_s;
  typedef enum logic [1:0] {
    DC_IDLE   = 2'b00,
    DC_LISTEN = 2'b01,
    DC_EXTEND = 2'b10
  } swbm_dc_e;
endpackage

/* rtl/swbm_top.sv */
// Wake-up timer, battery monitor and duty-cycle receive scheduler
// Contract
// - Flag supply below threshold, drive request
// - Monitor runs only while enabled
// - Level register readable, upper bits zero
// - Code: 50 mV steps from 1.7 V
// - Measure once per second for 250 us
// - Four consecutive low readings before interrupt
// - Monitor enabled in sleep starts oscillator (RC only, and only while crystal not selected)
// - Timer uses RC unless crystal selected
// - Timer counts in sleep, expiry interrupts
// - Period is 32 M 2^(R-D) slow ticks
// - Counter readable as two bytes, high first
// - Enabled expiry drives request low
// - Wake interrupt leaves sleep, starts crystal
// - Disabled interrupt: expiry only on pin
// - Crystal select routes pin crystal everywhere
// - Duty mode: listen each period, else sleep
// - Preamble and sync extend receive window
// - Extension is count times 2(R-D)32 ticks
`timescale 1ns/1ps
`default_nettype none
module swbm_top #(
  parameter int BAT_PERIOD = swbm_pkg::BAT_PERIOD_CYC,
  parameter int BAT_ON     = swbm_pkg::BAT_ON_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [6:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       battery_monitor_en_i,
  input  wire logic       wakeup_timer_en_i,
  input  wire logic       slow_crystal_select_i,
  input  wire logic       duty_cycle_en_i,
  input  wire logic [7:0] duty_cycle_count_i,
  input  wire logic       irq_en_battery_i,
  input  wire logic       irq_en_wakeup_i,
  input  wire logic       sleep_i,
  input  wire logic       status_clr_i,
  input  wire logic       slow_crystal_pin_i,
  input  wire logic [4:0] battery_code_i,
  input  wire logic       preamble_ok_i,
  input  wire logic       sync_ok_i,
  output logic            interrupt_request_out_n_o,
  output logic            status_battery_o,
  output logic            status_wakeup_o,
  output logic            rc_osc_on_o,
  output logic            battery_power_o,
  output logic            crystal_on_o,
  output logic            wakeup_pin_o,
  output logic            receiver_on_o
);

  ////////////////////////////////////////////////////////////////////
  // State
  swbm_pkg::swbm_period_s per_r, per_nxt;
  logic [4:0]  thr_r, thr_nxt;
  logic [4:0]  lvl_r, lvl_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic [1:0]  xs_r;
  logic [4:0]  bc1_r, bc2_r;
  logic        xprev_r;
  logic [10:0] rc_r, rc_nxt;
  logic [20:0] pre_r, pre_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [25:0] bper_r, bper_nxt;
  logic [13:0] bon_r, bon_nxt;
  logic        bpow_r, bpow_nxt;
  logic [2:0]  hits_r, hits_nxt;
  logic        stb_r, stb_nxt;
  logic        stw_r, stw_nxt;
  logic        xon_r, xon_nxt;
  logic        pin_r, pin_nxt;
  logic        run_r, run_nxt;
  logic        sleep_q_r;
  swbm_pkg::swbm_dc_e dc_r, dc_nxt;
  logic [17:0] dct_r, dct_nxt;
  logic        tick, expire;
  logic [20:0] pre_top;
  logic [17:0] ext_top;
  logic [3:0]  rmd;

  function automatic logic [20:0] prescale(input logic [3:0] e, input logic [1:0] d);
    logic [21:0] full;
    full = 22'({1'b0, swbm_pkg::PRESCALE_BASE} + 6'h01) << e;
    return 21'(full >> d);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Slow tick selection
  always_comb
  begin
    rc_nxt = (rc_r == 11'(swbm_pkg::RC_DIV_CYC - 1)) ? 11'h000 : rc_r + 11'h001;
    tick = slow_crystal_select_i ? (xs_r[1] & ~xprev_r)
                                 : (rc_r == 11'h000);
  end

  ////////////////////////////////////////////////////////////////////
  // Registers, timer, battery monitor, scheduler
  always_comb
  begin
    per_nxt = per_r;
    thr_nxt = thr_r;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        swbm_pkg::OFF_SCALE:   {per_nxt.expo, per_nxt.fine} = reg_wdata_i[5:0];
        swbm_pkg::OFF_MANT_HI: per_nxt.mant[15:8] = reg_wdata_i;
        swbm_pkg::OFF_MANT_LO: per_nxt.mant[7:0] = reg_wdata_i;
        swbm_pkg::OFF_BAT_THR: thr_nxt = reg_wdata_i[4:0];
        default:               thr_nxt = thr_r;
      endcase
    end
    rdata_nxt = rdata_r;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        swbm_pkg::OFF_SCALE:   rdata_nxt = {2'b00, per_r.expo, per_r.fine};
        swbm_pkg::OFF_MANT_HI: rdata_nxt = per_r.mant[15:8];
        swbm_pkg::OFF_MANT_LO: rdata_nxt = per_r.mant[7:0];
        swbm_pkg::OFF_CNT_HI:  rdata_nxt = cnt_r[15:8];
        swbm_pkg::OFF_CNT_LO:  rdata_nxt = cnt_r[7:0];
        swbm_pkg::OFF_BAT_THR: rdata_nxt = {3'b000, thr_r};
        swbm_pkg::OFF_BAT_LVL: rdata_nxt = {3'b000, lvl_r};
        default:               rdata_nxt = 8'h00;
      endcase
    end

    // Wake-up timer
    pre_top = prescale(per_r.expo, per_r.fine);
    run_nxt = sleep_i ? ((~sleep_q_r & wakeup_timer_en_i) | run_r) : 1'b0;
    pre_nxt = pre_r;
    cnt_nxt = cnt_r;
    expire = 1'b0;
    if (!run_r)
    begin
      pre_nxt = 21'h000000;
      cnt_nxt = 16'h0000;
    end
    else if (tick)
    begin
      if (pre_r + 21'h000001 >= pre_top)
      begin
        pre_nxt = 21'h000000;
        if (cnt_r + 16'h0001 >= per_r.mant && per_r.mant != 16'h0000)
        begin
          expire = 1'b1;
          cnt_nxt = 16'h0000;
        end
        else
          cnt_nxt = cnt_r + 16'h0001;
      end
      else
        pre_nxt = pre_r + 21'h000001;
    end
    stw_nxt = (stw_r & ~status_clr_i) | (expire & irq_en_wakeup_i);
    pin_nxt = expire & ~irq_en_wakeup_i;
    xon_nxt = xon_r;
    if (sleep_i & ~sleep_q_r)
      xon_nxt = 1'b0;
    if (expire & irq_en_wakeup_i)
      xon_nxt = 1'b1;

    // Battery monitor
    bper_nxt = bper_r;
    bon_nxt = bon_r;
    bpow_nxt = bpow_r;
    lvl_nxt = lvl_r;
    hits_nxt = hits_r;
    if (!battery_monitor_en_i)
    begin
      bper_nxt = 26'h0000000;
      bon_nxt = 14'h0000;
      bpow_nxt = 1'b0;
      hits_nxt = 3'h0;
    end
    else
    begin
      bper_nxt = (bper_r == 26'(BAT_PERIOD - 1)) ? 26'h0000000 : bper_r + 26'h0000001;
      if (bper_r == 26'h0000000)
      begin
        bpow_nxt = 1'b1;
        bon_nxt = 14'h0000;
      end
      else if (bpow_r)
      begin
        bon_nxt = bon_r + 14'h0001;
        if (bon_r == 14'(BAT_ON - 1))
        begin
          bpow_nxt = 1'b0;
          lvl_nxt = bc2_r;
          if (bc2_r < thr_r)
            hits_nxt = (hits_r == swbm_pkg::BAT_HITS) ? hits_r : hits_r + 3'h1;
          else
            hits_nxt = 3'h0;
        end
      end
    end
    stb_nxt = (stb_r & ~status_clr_i)
            | (irq_en_battery_i & hits_nxt == swbm_pkg::BAT_HITS
               & hits_r != swbm_pkg::BAT_HITS);

    // Duty-cycle receive scheduler
    rmd = (per_r.expo > {2'b00, per_r.fine}) ? per_r.expo - {2'b00, per_r.fine} : 4'h0;
    ext_top = 18'(duty_cycle_count_i * rmd * 7'h40);
    dc_nxt = dc_r;
    dct_nxt = dct_r;
    if (tick)
      dct_nxt = dct_r + 18'h00001;
    case (dc_r)
      swbm_pkg::DC_IDLE:
      begin
        dct_nxt = 18'h00000;
        if (duty_cycle_en_i & expire)
          dc_nxt = swbm_pkg::DC_LISTEN;
      end
      swbm_pkg::DC_LISTEN:
      begin
        if (preamble_ok_i & sync_ok_i)
        begin
          dc_nxt = swbm_pkg::DC_EXTEND;
          dct_nxt = 18'h00000;
        end
        else if (dct_r >= 18'(swbm_pkg::LISTEN_TICKS))
          dc_nxt = swbm_pkg::DC_IDLE;
      end
      swbm_pkg::DC_EXTEND:
      begin
        if (dct_r >= ext_top)
          dc_nxt = swbm_pkg::DC_IDLE;
      end
      default: dc_nxt = swbm_pkg::DC_IDLE;
    endcase
    if (!duty_cycle_en_i)
      dc_nxt = swbm_pkg::DC_IDLE;
  end

  always_ff @(posedge clk_i)
  begin
    xs_r <= {xs_r[0], slow_crystal_pin_i};
    xprev_r <= xs_r[1];
    bc1_r <= battery_code_i;
    bc2_r <= bc1_r;
    if (sys_rst_i)
    begin
      per_r <= {swbm_pkg::RST_SCALE[5:0], swbm_pkg::RST_MANT, swbm_pkg::RST_MANT};
      thr_r <= swbm_pkg::RST_BAT_THR[4:0];
      lvl_r <= 5'h00;
      rdata_r <= 8'h00;
      rc_r <= 11'h000;
      pre_r <= 21'h000000;
      cnt_r <= 16'h0000;
      bper_r <= 26'h0000000;
      bon_r <= 14'h0000;
      bpow_r <= 1'b0;
      hits_r <= 3'h0;
      stb_r <= 1'b0;
      stw_r <= 1'b0;
      xon_r <= 1'b0;
      pin_r <= 1'b0;
      run_r <= 1'b0;
      sleep_q_r <= 1'b0;
      dc_r <= swbm_pkg::DC_IDLE;
      dct_r <= 18'h00000;
    end
    else
    begin
      per_r <= per_nxt;
      thr_r <= thr_nxt;
      lvl_r <= lvl_nxt;
      rdata_r <= rdata_nxt;
      rc_r <= rc_nxt;
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      bper_r <= bper_nxt;
      bon_r <= bon_nxt;
      bpow_r <= bpow_nxt;
      hits_r <= hits_nxt;
      stb_r <= stb_nxt;
      stw_r <= stw_nxt;
      xon_r <= xon_nxt;
      pin_r <= pin_nxt;
      run_r <= run_nxt;
      sleep_q_r <= sleep_i;
      dc_r <= dc_nxt;
      dct_r <= dct_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata_o = rdata_r;
  assign interrupt_request_out_n_o = ~(stb_r | stw_r);
  assign status_battery_o = stb_r;
  assign status_wakeup_o = stw_r;
  assign rc_osc_on_o = ~slow_crystal_select_i
                     & (battery_monitor_en_i | run_r);
  assign battery_power_o = bpow_r;
  assign crystal_on_o = xon_r;
  assign wakeup_pin_o = pin_r;
  assign receiver_on_o = (dc_r != swbm_pkg::DC_IDLE);

endmodule
`default_nettype wire

/* tb/swbm_checker.sv */
// Port assertions for the wake-up and battery monitor block
`timescale 1ns/1ps
`default_nettype none
module swbm_checker #(
  parameter int BAT_ON = swbm_pkg::BAT_ON_CYC
) (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       battery_monitor_en_i,
  input wire logic       irq_en_battery_i,
  input wire logic       irq_en_wakeup_i,
  input wire logic       sleep_i,
  input wire logic       status_clr_i,
  input wire logic       interrupt_request_out_n_o,
  input wire logic       status_battery_o,
  input wire logic       status_wakeup_o,
  input wire logic       rc_osc_on_o,
  input wire logic       battery_power_o,
  input wire logic       crystal_on_o,
  input wire logic       wakeup_pin_o
);
  int pwr_cnt_r;
  int pwr_cnt_nxt;
  always_comb pwr_cnt_nxt = battery_power_o ? pwr_cnt_r + 1 : 0;
  always_ff @(posedge clk_i) pwr_cnt_r <= sys_rst_i ? 0 : pwr_cnt_nxt;
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  irq_level_a: assert property (interrupt_request_out_n_o == !(status_battery_o || status_wakeup_o))
    else $error("request line disagrees with flags");
  bat_irq_a: assert property ($rose(status_battery_o) |-> $past(irq_en_battery_i))
    else $error("battery flag set while disabled");
  bat_off_a: assert property (!battery_monitor_en_i ##1 !battery_monitor_en_i |-> !battery_power_o)
    else $error("monitor powered while disabled");
  bat_window_a: assert property ($fell(battery_power_o) && battery_monitor_en_i |-> pwr_cnt_r == BAT_ON)
    else $error("measurement window length wrong");
  rc_sleep_a: assert property (sleep_i && battery_monitor_en_i |-> rc_osc_on_o)
    else $error("oscillator off while monitor sleeps");
  level_rd_a: assert property (reg_rd_i && reg_addr_i == swbm_pkg::OFF_BAT_LVL |=> reg_rdata_o[7:5] == 3'h0)
    else $error("level upper bits not zero");
  awake_a: assert property (!sleep_i && !$past(sleep_i) && !$past(sleep_i, 2) |-> !$rose(status_wakeup_o))
    else $error("wake expiry while awake");
  xtal_a: assert property ($rose(status_wakeup_o) |-> crystal_on_o)
    else $error("crystal off on wake interrupt");
  pin_pulse_a: assert property (wakeup_pin_o |-> !$past(irq_en_wakeup_i) ##1 !wakeup_pin_o)
    else $error("bad wake pin pulse");
  sticky_a: assert property (status_wakeup_o && !status_clr_i |=> status_wakeup_o)
    else $error("wake flag dropped");
  cover property ($rose(status_battery_o));
  cover property ($rose(status_wakeup_o));
  cover property ($rose(wakeup_pin_o));
endmodule
bind swbm_top swbm_checker #(.BAT_ON(BAT_ON)) i_swbm_checker (.clk_i, .sys_rst_i, .reg_addr_i,
  .reg_rd_i, .reg_rdata_o, .battery_monitor_en_i, .irq_en_battery_i, .irq_en_wakeup_i, .sleep_i,
  .status_clr_i, .interrupt_request_out_n_o, .status_battery_o, .status_wakeup_o, .rc_osc_on_o,
  .battery_power_o, .crystal_on_o, .wakeup_pin_o);
`default_nettype wire

/* tb/swbm_mcu_model.sv */
// Controller model that services the interrupt request
`timescale 1ns/1ps
`default_nettype none
module swbm_mcu_model (
  input  wire logic       clk_i,
  input  wire logic       service_i,
  input  wire logic       irq_n_i,
  input  wire logic       status_battery_i,
  input  wire logic       status_wakeup_i,
  output logic            clr_o,
  output logic      [1:0] seen_o
);
  always @(negedge clk_i)
  begin
    clr_o <= 1'b0;
    if (service_i && !irq_n_i && !clr_o)
    begin
      seen_o <= {status_wakeup_i, status_battery_i};
      clr_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* tb/tb_sleep_wakeup_battery_monitor.sv */
// Self-checking bench for the wake-up and battery monitor block
`timescale 1ns/1ps
`default_nettype none
module tb_sleep_wakeup_battery_monitor;
  logic       clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, sleep_i = 1'b0;
  logic       battery_monitor_en_i = 1'b0, wakeup_timer_en_i = 1'b0, duty_cycle_en_i = 1'b0;
  logic       irq_en_battery_i = 1'b0, irq_en_wakeup_i = 1'b0, service = 1'b0, status_clr_i;
  logic [6:0] reg_addr_i = 7'h00;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
  logic [4:0] battery_code_i = 5'h00;
  logic [7:0] duty_cycle_count_i = 8'h00;
  logic       preamble_ok_i = 1'b0, sync_ok_i = 1'b0;
  logic [1:0] seen;
  logic       interrupt_request_out_n_o, status_battery_o, status_wakeup_o, rc_osc_on_o;
  logic       battery_power_o, crystal_on_o, wakeup_pin_o, receiver_on_o;
  int         num_errors = 0, num_checks = 0;
  swbm_top #(.BAT_PERIOD(200), .BAT_ON(20)) i_swbm_top (.clk_i, .sys_rst_i, .reg_addr_i,
    .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .battery_monitor_en_i, .wakeup_timer_en_i,
    .slow_crystal_select_i(1'b0), .duty_cycle_en_i, .duty_cycle_count_i, .irq_en_battery_i,
    .irq_en_wakeup_i, .sleep_i, .status_clr_i, .slow_crystal_pin_i(1'b0), .battery_code_i,
    .preamble_ok_i, .sync_ok_i, .interrupt_request_out_n_o, .status_battery_o,
    .status_wakeup_o, .rc_osc_on_o, .battery_power_o, .crystal_on_o, .wakeup_pin_o, .receiver_on_o);
  swbm_mcu_model i_swbm_mcu_model (.clk_i, .service_i(service), .irq_n_i(interrupt_request_out_n_o),
    .status_battery_i(status_battery_o), .status_wakeup_i(status_wakeup_o), .clr_o(status_clr_i),
    .seen_o(seen));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd_reg(input logic [6:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, exp);
  endtask
  task automatic close_out;
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_reg(swbm_pkg::OFF_BAT_THR, swbm_pkg::RST_BAT_THR);
    rd_reg(swbm_pkg::OFF_SCALE, swbm_pkg::RST_SCALE);
    rd_reg(7'h20, 8'h00);
    repeat (300) @(negedge clk_i);
    chk(8'({battery_power_o, interrupt_request_out_n_o}), 8'h01);
  endtask
  task automatic t_battery;
    wr_reg(swbm_pkg::OFF_BAT_THR, 8'h10);
    battery_code_i = 5'h05;
    irq_en_battery_i = 1'b1;
    battery_monitor_en_i = 1'b1;
    repeat (610) @(negedge clk_i);
    chk(8'(status_battery_o), 8'h00);
    for (int i = 0; i < 100 && status_battery_o !== 1'b1; i++) @(negedge clk_i);
    chk(8'(interrupt_request_out_n_o), 8'h00);
    rd_reg(swbm_pkg::OFF_BAT_LVL, 8'h05);
    service = 1'b1;
    repeat (3) @(negedge clk_i);
    chk(8'({seen, interrupt_request_out_n_o}), 8'h03);
    service = 1'b0;
    battery_code_i = 5'h1F;
  endtask
  task automatic t_wakeup;
    wr_reg(swbm_pkg::OFF_SCALE, 8'h03);
    wr_reg(swbm_pkg::OFF_MANT_LO, 8'h01);
    irq_en_wakeup_i = 1'b1;
    wakeup_timer_en_i = 1'b1;
    duty_cycle_en_i = 1'b1;
    duty_cycle_count_i = 8'h05;
    sleep_i = 1'b1;
    @(negedge clk_i);
    chk(8'(rc_osc_on_o), 8'h01);
    repeat (3000) @(negedge clk_i);
    chk(8'(status_wakeup_o), 8'h00);
    for (int i = 0; i < 4000 && status_wakeup_o !== 1'b1; i++) @(negedge clk_i);
    chk(8'({status_wakeup_o, crystal_on_o, interrupt_request_out_n_o}), 8'h06);
    repeat (2) @(negedge clk_i);
    chk(8'(receiver_on_o), 8'h01);
    preamble_ok_i = 1'b1;
    sync_ok_i = 1'b1;
    @(negedge clk_i);
    chk(8'(receiver_on_o), 8'h01);
    @(negedge clk_i);
    chk(8'(receiver_on_o), 8'h00);
    preamble_ok_i = 1'b0;
    sync_ok_i = 1'b0;
    wr_reg(swbm_pkg::OFF_CNT_HI, 8'hAA);
    rd_reg(swbm_pkg::OFF_CNT_HI, 8'h00);
    rd_reg(swbm_pkg::OFF_CNT_LO, 8'h00);
    service = 1'b1;
    repeat (3) @(negedge clk_i);
    chk(8'({seen, interrupt_request_out_n_o}), 8'h05);
    service = 1'b0;
    irq_en_wakeup_i = 1'b0;
    for (int i = 0; i < 6000 && wakeup_pin_o !== 1'b1; i++) @(negedge clk_i);
    chk(8'({wakeup_pin_o, status_wakeup_o}), 8'h02);
    wr_reg(swbm_pkg::OFF_MANT_LO, 8'h03);
    repeat (7300) @(negedge clk_i);
    rd_reg(swbm_pkg::OFF_CNT_LO, 8'h01);
    sleep_i = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #12.5 clk_i = ~clk_i;
  initial
  begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    close_out();
  end
  initial
  begin
    repeat (8) @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_battery();
    t_wakeup();
    close_out();
  end
endmodule
`default_nettype wire
